// ===== hdl/alarm_unit_consts.svh
// Purpose: named constants for the safety alarm unit
// Assumes: word-wide register port, one clock
// Notes:   definitions only
`ifndef ALARM_UNIT_CONSTS_SVH
`define ALARM_UNIT_CONSTS_SVH
`define AU_W            32
`define AU_ADDR_W       4
// register indices on the word port
`define AU_IDX_AG0      4'h0
`define AU_IDX_AG7      4'h1
`define AU_IDX_AG21     4'h2
`define AU_IDX_STERR    4'h3
`define AU_IDX_STDONE   4'h4
`define AU_IDX_STCTL    4'h5
`define AU_IDX_CLKCTL   4'h6
`define AU_IDX_STATUS   4'h7
`define AU_IDX_BIST_FS  4'h8
`define AU_IDX_BIST_ECC 4'h9
// documented bist controller addresses
`define AU_BIST_FS_ADDR  32'hF00638F0
`define AU_BIST_ECC_ADDR 32'hF0063810
// field positions
`define AU_AG7_BIT0     0
`define AU_AG7_BIT1     1
`define AU_AG21_PMS_BIT 7
`define AU_STCTL_PMS    5
`define AU_ST_SAFFF     5
`define AU_CLK_DIS      0
`define AU_STS_PIN      0
`define AU_STS_CORE_OFF 1
// reset values
`define AU_AG7_RST      32'h00000003
`define AU_ZERO         32'h00000000
`define AU_ONES         32'hFFFFFFFF
`define AU_HALF_ZERO    16'h0000
`define AU_BIST_RST     16'hFFFF
`define AU_DIV_RST      2'h0
// standby monitor samples when the divider equals this, one cycle in four
`define AU_STBY_DIV     2'h3
`endif

// ===== hdl/alarm_unit_pkg.sv
// Purpose: types for the safety alarm unit
// Assumes: nothing
// Notes:   constants live in the header
`default_nettype none
package alarm_unit_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  idx;
        logic [31:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic pin_o;
        logic pin_oe;
    } err_pin_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b10
    } st_state_t;
endpackage
`default_nettype wire

// ===== hdl/safety_alarm_unit.sv
// Purpose: alarm flag store, self-test, fault pin for a safety alarm unit
// Assumes: inputs synchronous to sys_clk_i, full-word register port
// Notes:   bist controller halves reached at their own indices
`include "alarm_unit_consts.svh"
`default_nettype none
// Notes on behaviour
// - Alarm group flags clear where a written bit is one; group seven only once both bist halves are zero.
// - Self-test error and done flags clear where a written bit is zero.
// - Alarm reactions fire from raw events regardless of flag clears.
// - Alarm group seven bits 1 and 0 are set after every reset.
// - The clock control disable bit can switch the core monitor off.
// - A standby monitor fault releases the error pin to high impedance.
// - While released, status bit 0 and the port input bit do not show the pin.
// - While released, the pin emergency stop produces no event.
// - Group 21 bit 7 may be missed after self-test with power module on.
// - The standby monitor samples slowly, so short pulses may be missed.
// - Self-test done flag at bit 5 reports correctly; with the power module on, the fail flag at bit 5 sets when the flip-flop is healthy.
// - The power flip-flop error goes to both monitors, self-test to core only.
module safety_alarm_unit (
    input  wire logic                    sys_clk_i,
    input  wire logic                    arst_n_i,
    input  wire alarm_unit_pkg::reg_req_t req_i,
    output logic [31:0]                  rdata_o,
    input  wire logic [31:0]             ag0_evt_i,
    input  wire logic                    pms_ff_err_i,
    input  wire logic                    stby_fault_i,
    input  wire logic                    pin_i,
    output alarm_unit_pkg::err_pin_t     err_pin_o,
    output logic                         alarm_action_o,
    output logic                         estop_o,
    output logic                         port_in_o
);
    // alarm flag group
    logic [31:0]               ag0_r;
    logic [31:0]               ag0_nxt;
    logic [31:0]               ag7_r;
    logic [31:0]               ag7_nxt;
    logic [31:0]               ag21_r;
    logic [31:0]               ag21_nxt;
    logic [31:0]               clk_r;
    logic [31:0]               clk_nxt;
    logic [15:0]               bfs_r;
    logic [15:0]               bfs_nxt;
    logic [15:0]               becc_r;
    logic [15:0]               becc_nxt;
    logic [1:0]                div_r;
    logic [1:0]                div_nxt;
    // self-test group
    alarm_unit_pkg::st_state_t st_r;
    alarm_unit_pkg::st_state_t st_nxt;
    logic [31:0]               sterr_r;
    logic [31:0]               sterr_nxt;
    logic [31:0]               stdone_r;
    logic [31:0]               stdone_nxt;
    logic [31:0]               stctl_r;
    logic [31:0]               stctl_nxt;
    // pin, reaction and read group
    logic                      hiz_r;
    logic                      hiz_nxt;
    logic                      pin_r;
    logic                      pin_nxt;
    logic                      act_r;
    logic                      act_nxt;
    logic [31:0]               rdata_r;
    logic [31:0]               rdata_nxt;
    // shared decodes
    logic                      core_on;
    logic                      stby_tick;
    logic                      st_go;
    logic                      wr_ag7;
    logic                      ag7_gate;
    // =====================================================================
    // shared decodes
    always_comb begin
        core_on   = ~clk_r[`AU_CLK_DIS];
        stby_tick = (div_r == `AU_STBY_DIV);
        st_go     = req_i.wr && (req_i.idx == `AU_IDX_STCTL);
        wr_ag7    = req_i.wr && (req_i.idx == `AU_IDX_AG7);
        // bist halves must be zero before group seven can clear
        ag7_gate  = (bfs_r == `AU_HALF_ZERO) && (becc_r == `AU_HALF_ZERO);
    end
    // =====================================================================
    // alarm flag group
    always_comb begin
        div_nxt  = div_r + 2'h1;
        ag0_nxt  = ag0_r;
        ag7_nxt  = ag7_r;
        ag21_nxt = ag21_r;
        clk_nxt  = clk_r;
        bfs_nxt  = bfs_r;
        becc_nxt = becc_r;
        if (req_i.wr) begin
            unique case (req_i.idx)
                `AU_IDX_AG0:      ag0_nxt  = ag0_r & ~req_i.wdata;
                `AU_IDX_AG21:     ag21_nxt = ag21_r & ~req_i.wdata;
                `AU_IDX_CLKCTL:   clk_nxt  = req_i.wdata;
                `AU_IDX_BIST_FS:  bfs_nxt  = req_i.wdata[15:0];
                `AU_IDX_BIST_ECC: becc_nxt = req_i.wdata[15:0];
                default: ;
            endcase
        end
        if (wr_ag7 && ag7_gate) begin
            ag7_nxt = ag7_r & ~req_i.wdata;
        end
        // events land after clears, so a clear never hides a same-cycle event
        if (core_on) begin
            ag0_nxt = ag0_nxt | ag0_evt_i;
        end
        // standby side sees the power error only on its slow tick
        if (stby_tick && pms_ff_err_i) begin
            ag21_nxt[`AU_AG21_PMS_BIT] = 1'b1;
        end
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ag0_r  <= `AU_ZERO;
            ag7_r  <= `AU_AG7_RST;
            ag21_r <= `AU_ZERO;
            clk_r  <= `AU_ZERO;
            bfs_r  <= `AU_BIST_RST;
            becc_r <= `AU_BIST_RST;
            div_r  <= `AU_DIV_RST;
        end else begin
            ag0_r  <= ag0_nxt;
            ag7_r  <= ag7_nxt;
            ag21_r <= ag21_nxt;
            clk_r  <= clk_nxt;
            bfs_r  <= bfs_nxt;
            becc_r <= becc_nxt;
            div_r  <= div_nxt;
        end
    end
    // =====================================================================
    // self-test group
    always_comb begin
        st_nxt     = st_r;
        sterr_nxt  = sterr_r;
        stdone_nxt = stdone_r;
        stctl_nxt  = stctl_r;
        if (req_i.wr) begin
            unique case (req_i.idx)
                `AU_IDX_STERR:  sterr_nxt  = sterr_r & req_i.wdata;
                `AU_IDX_STDONE: stdone_nxt = stdone_r & req_i.wdata;
                `AU_IDX_STCTL:  stctl_nxt  = req_i.wdata;
                default: ;
            endcase
        end
        // completion lands after the clear, so the set wins a same-cycle write
        unique case (st_r)
            alarm_unit_pkg::ST_IDLE: begin
                if (st_go) begin
                    st_nxt = alarm_unit_pkg::ST_RUN;
                end
            end
            alarm_unit_pkg::ST_RUN: begin
                st_nxt = alarm_unit_pkg::ST_DONE;
                stdone_nxt[`AU_ST_SAFFF] = 1'b1;
                // with the power module on, a healthy flip-flop raises its error
                if (stctl_r[`AU_STCTL_PMS] && !pms_ff_err_i) begin
                    sterr_nxt[`AU_ST_SAFFF] = 1'b1;
                end
            end
            alarm_unit_pkg::ST_DONE: st_nxt = alarm_unit_pkg::ST_IDLE;
            default:                 st_nxt = alarm_unit_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r     <= alarm_unit_pkg::ST_IDLE;
            sterr_r  <= `AU_ZERO;
            stdone_r <= `AU_ZERO;
            stctl_r  <= `AU_ZERO;
        end else begin
            st_r     <= st_nxt;
            sterr_r  <= sterr_nxt;
            stdone_r <= stdone_nxt;
            stctl_r  <= stctl_nxt;
        end
    end
    // =====================================================================
    // error pin and reaction group
    always_comb begin
        // release is sticky: only a reset brings the pin back
        hiz_nxt = hiz_r | stby_fault_i;
        // port copy freezes while released, so it never shows the pin
        pin_nxt = hiz_r ? pin_r : pin_i;
        act_nxt = core_on && ((|ag0_evt_i) || pms_ff_err_i);
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hiz_r <= 1'b0;
            pin_r <= 1'b0;
            act_r <= 1'b0;
        end else begin
            hiz_r <= hiz_nxt;
            pin_r <= pin_nxt;
            act_r <= act_nxt;
        end
    end
    // =====================================================================
    // read data group
    always_comb begin
        rdata_nxt = rdata_r;
        if (req_i.rd) begin
            unique case (req_i.idx)
                `AU_IDX_AG0:      rdata_nxt = ag0_r;
                `AU_IDX_AG7:      rdata_nxt = ag7_r;
                `AU_IDX_AG21:     rdata_nxt = ag21_r;
                `AU_IDX_STERR:    rdata_nxt = sterr_r;
                `AU_IDX_STDONE:   rdata_nxt = stdone_r;
                `AU_IDX_STCTL:    rdata_nxt = stctl_r;
                `AU_IDX_CLKCTL:   rdata_nxt = clk_r;
                `AU_IDX_STATUS: begin
                    rdata_nxt                   = `AU_ZERO;
                    rdata_nxt[`AU_STS_PIN]      = pin_r;
                    rdata_nxt[`AU_STS_CORE_OFF] = ~core_on;
                end
                `AU_IDX_BIST_FS:  rdata_nxt = {16'h0000, bfs_r};
                `AU_IDX_BIST_ECC: rdata_nxt = {16'h0000, becc_r};
                default:          rdata_nxt = `AU_ZERO;
            endcase
        end
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_r <= `AU_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
    // =====================================================================
    // outputs
    assign rdata_o          = rdata_r;
    assign err_pin_o.pin_o  = 1'b0;
    assign err_pin_o.pin_oe = core_on & ~hiz_r;
    assign alarm_action_o   = act_r;
    assign port_in_o        = pin_r;
    assign estop_o          = ~hiz_r & ~pin_r & core_on;
endmodule // safety_alarm_unit
`default_nettype wire

// ===== tb/safety_alarm_unit_properties.sv
// Purpose: port assertions for safety_alarm_unit
// Assumes: one clock, asynchronous active-low reset
// Notes:   register effects tracked from req_i
`default_nettype none
module safety_alarm_unit_properties (
    input wire logic                     sys_clk_i,
    input wire logic                     arst_n_i,
    input wire alarm_unit_pkg::reg_req_t req_i,
    input wire logic [31:0]              rdata_o,
    input wire logic [31:0]              ag0_evt_i,
    input wire logic                     stby_fault_i,
    input wire alarm_unit_pkg::err_pin_t err_pin_o,
    input wire logic                     alarm_action_o,
    input wire logic                     estop_o,
    input wire logic                     port_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic core_off_r;
    logic ag7_fresh_r;
    logic stby_seen_r;
    // ==================================
    // helper state seen from the register port and the standby fault input
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            core_off_r  <= 1'b0;
            ag7_fresh_r <= 1'b1;
            stby_seen_r <= 1'b0;
        end else begin
            // release is sticky until reset
            stby_seen_r <= stby_seen_r | stby_fault_i;
            if (req_i.wr && req_i.idx == 4'h6) core_off_r <= req_i.wdata[0];
            if (req_i.wr && req_i.idx == 4'h1) ag7_fresh_r <= 1'b0;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    AST_HIZ_ON_FAULT: assert property (stby_fault_i |-> ##[0:4] !err_pin_o.pin_oe)
        else $error("pin not released after standby fault");
    AST_HIZ_HOLD: assert property (stby_seen_r |-> !err_pin_o.pin_oe)
        else $error("released pin driven again");
    AST_ESTOP_OFF: assert property (!err_pin_o.pin_oe |-> !estop_o)
        else $error("emergency stop while pin released");
    AST_PORTIN_FROZEN: assert property (stby_seen_r |=> $stable(port_in_o))
        else $error("port input moved while released");
    AST_ACTION: assert property ((|ag0_evt_i) && !core_off_r |=> alarm_action_o)
        else $error("no alarm action after event");
    AST_AG7_SET: assert property (req_i.rd && req_i.idx == 4'h1 && ag7_fresh_r
        |=> rdata_o[1:0] == 2'h3)
        else $error("group seven flags not set after reset");
    AST_W1C: assert property (req_i.wr && req_i.idx == 4'h0 && req_i.wdata[2]
        && !ag0_evt_i[2] ##1 !ag0_evt_i[2]
        ##1 req_i.rd && req_i.idx == 4'h0 && !ag0_evt_i[2] |=> !rdata_o[2])
        else $error("group flag not cleared by one");
    AST_DONE: assert property (req_i.wr && req_i.idx == 4'h5
        ##3 req_i.rd && req_i.idx == 4'h4 |=> rdata_o[5])
        else $error("self-test done flag missing");
    cover property (!err_pin_o.pin_oe);
    cover property (alarm_action_o);
    cover property (req_i.rd && req_i.idx == 4'h4);
endmodule // safety_alarm_unit_properties
`default_nettype wire

// ===== tb/err_pin_wire.sv
// Purpose: error pin wire with external pull-down and far-side driver
// Assumes: design drives the pin low only
// Notes:   contention while driven is not modelled
`default_nettype none
module err_pin_wire (
    input  wire alarm_unit_pkg::err_pin_t drv_i,
    input  wire logic                     ext_high_i,
    output logic                          level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pin falls to the pull-down unless driven high outside
    assign level_o = drv_i.pin_oe ? drv_i.pin_o : ext_high_i;
endmodule // err_pin_wire
`default_nettype wire

// ===== tb/test_safety_alarm_unit.sv
// Purpose: self-checking bench for safety_alarm_unit
// Assumes: full-word register accesses only
// Notes:   random group 0 events and clear masks
`default_nettype none
module test_safety_alarm_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0, arst_n_i = 1'b0, power_management_module = 1'b0, stby = 1'b0, ext_high = 1'b0;
    alarm_unit_pkg::reg_req_t req = '0;
    alarm_unit_pkg::err_pin_t pin_drv;
    logic [31:0] evt = 32'h0, rdata, rd_val, exp_ag0, m, seed = 32'h728D9FD6;
    logic        pin_lvl, action, estop, port_in;
    int          miscompares = 0, cmp_count = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    safety_alarm_unit u_dut (.sys_clk_i, .arst_n_i, .req_i(req), .rdata_o(rdata),
        .ag0_evt_i(evt), .pms_ff_err_i(power_management_module), .stby_fault_i(stby), .pin_i(pin_lvl),
        .err_pin_o(pin_drv), .alarm_action_o(action), .estop_o(estop), .port_in_o(port_in));
    err_pin_wire u_pin (.drv_i(pin_drv), .ext_high_i(ext_high), .level_o(pin_lvl));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic acc(input logic w, input logic [3:0] i, input logic [31:0] d);
        @(posedge sys_clk_i) req <= '{w, !w, i, d};
        @(posedge sys_clk_i) req <= '0;
        @(negedge sys_clk_i) rd_val = rdata;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk(input logic [3:0] i, input logic [31:0] e, input string n);
        acc(1'b0, i, 32'h0);
        cmp(n, e, rd_val);
    endtask
    task automatic results;
        $display("mismatches %0d comparisons %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        chk(4'h1, 32'h3, "ag7 after reset");
        acc(1'b1, 4'h1, 32'h3);
        chk(4'h1, 32'h3, "ag7 clear refused");
        acc(1'b1, 4'h8, 32'h0);
        acc(1'b1, 4'h9, 32'h0);
        acc(1'b1, 4'h1, 32'h3);
        chk(4'h1, 32'h0, "ag7 cleared");
        exp_ag0 = 32'h0;
        for (int k = 0; k < 40; k++) begin
            seed = xs(seed);
            @(posedge sys_clk_i) evt <= seed & 32'h0F0F0F0F;
            @(posedge sys_clk_i) evt <= 32'h0;
            exp_ag0 = exp_ag0 | (seed & 32'h0F0F0F0F);
            @(negedge sys_clk_i);
            cmp("action", 32'(|(seed & 32'h0F0F0F0F)), 32'(action));
            m = (k == 0) ? 32'h00000004 : xs(seed);
            acc(1'b1, 4'h0, m);
            exp_ag0 = exp_ag0 & ~m;
            chk(4'h0, exp_ag0, "ag0 flags");
        end
        acc(1'b1, 4'h5, 32'h20);
        @(posedge sys_clk_i);
        chk(4'h4, 32'h20, "done flag");
        chk(4'h3, 32'h20, "fail flag");
        acc(1'b1, 4'h4, 32'hFFFFFFFB);
        chk(4'h4, 32'h20, "done kept");
        acc(1'b1, 4'h3, 32'hFFFFFFDF);
        chk(4'h3, 32'h0, "fail cleared");
        @(posedge sys_clk_i) power_management_module <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        acc(1'b0, 4'h2, 32'h0);
        cmp("ag21 bit7", 32'h80, rd_val & 32'h80);
        @(posedge sys_clk_i) power_management_module <= 1'b0;
        acc(1'b1, 4'h2, 32'h80);
        chk(4'h2, 32'h0, "ag21 cleared");
        acc(1'b1, 4'h6, 32'h1);
        chk(4'h6, 32'h1, "clock control poll");
        acc(1'b0, 4'h7, 32'h0);
        cmp("core off", 32'h2, rd_val & 32'h2);
        acc(1'b1, 4'h6, 32'h0);
        cmp("estop driven", 32'h1, 32'(estop));
        cmp("pin enable driven", 32'h1, 32'(pin_drv.pin_oe));
        cmp("pin driven low", 32'h0, 32'(pin_lvl));
        @(posedge sys_clk_i) stby <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        ext_high <= 1'b1;
        acc(1'b0, 4'h7, 32'h0);
        cmp("status pin", 32'h0, rd_val & 32'h1);
        cmp("pin enable", 32'h0, 32'(pin_drv.pin_oe));
        cmp("port input", 32'h0, 32'(port_in));
        cmp("estop", 32'h0, 32'(estop));
        results();
    end
    initial begin
        repeat (4000) @(posedge sys_clk_i);
        miscompares++;
        results();
    end
endmodule // test_safety_alarm_unit
bind safety_alarm_unit safety_alarm_unit_properties u_props (.sys_clk_i, .arst_n_i, .req_i,
    .rdata_o, .ag0_evt_i, .stby_fault_i, .err_pin_o, .alarm_action_o, .estop_o, .port_in_o);
`default_nettype wire
